// ==== logic/tug3_sink_pkg.sv ====
// Purpose: shared constants and carriers for the tug3 lower order sink
// Assumes: mclk at 250 MHz, link clock sampled as a plain input
// Notes: pointer interpreter reduced to ais/lop detection on the pointer word
package tug3_sink_pkg;
    localparam int CLK_MHZ = 250;
    localparam int TU3_AIS_US = 250;
    localparam int TU2_AIS_US = 1000;
    localparam int LOM_MS = 2;
    localparam int LOM_CYC = LOM_MS * 1000 * CLK_MHZ;
    localparam logic [2:0] EXP_LABEL = 3'b100;
    localparam logic [1:0] MF_BIT_LO = 2'd0;
    localparam int MF_RECOVER = 4;
    localparam int LABEL_HI = 5;
    localparam int LABEL_LO = 3;
    localparam int MFB_HI = 7;
    localparam int MFB_LO = 6;
    localparam int PI_NDF_CNT = 8;
    localparam int PI_AIS_CNT = 3;
    localparam logic [15:0] PTR_ALL_ONES = 16'hffff;
    localparam logic [7:0] DATA_ONES = 8'hff;
    localparam logic [1:0] K_A = 2'd0;
    localparam logic [1:0] K_B = 2'd1;
    localparam logic [1:0] K_C = 2'd2;
    localparam logic [2:0] L_MAX_AB = 3'd7;
    localparam logic [2:0] L_MAX_C = 3'd5;

    typedef struct packed {
        logic [7:0] data;
        logic fs;
        logic mfs;
    } stream_t;

    typedef struct packed {
        logic all_ones_insert_action;
        logic server_fail_out_action;
        logic alarm_signal_fault_cause;
        logic pointer_loss_fault_cause;
    } sink_stat_t;

    typedef enum logic [1:0] {PI_NORM, PI_AIS, PI_LOP} pi_state_t;

    function automatic logic [31:0] us_to_cyc(input int us);
        us_to_cyc = 32'(us * CLK_MHZ);
    endfunction : us_to_cyc
endpackage : tug3_sink_pkg

// ==== logic/ptr_sink.sv ====
// Purpose: one tu pointer-interpreting adaptation sink
// Assumes: slot_hit marks bytes of the selected timeslot, ptr_hi and ptr_lo the pointer pair
// Notes: all-ones insertion and release are applied on the next slot byte
`timescale 1ns/10ps
`default_nettype none
module ptr_sink
    import tug3_sink_pkg::*;
#(
    parameter int AIS_US = TU3_AIS_US
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic slot_hit,
    input wire logic ptr_hi,
    input wire logic ptr_lo,
    input wire stream_t stream_in,
    input wire logic trail_fail_in,
    input wire logic function_activate,
    input wire logic alarm_report_enable,
    output stream_t sink_data_out,
    output sink_stat_t stat
);
    localparam logic [31:0] AIS_CYC = us_to_cyc(AIS_US);
    pi_state_t pi_r;
    logic [7:0] hi_r;
    logic [3:0] ndf_cnt_r, ais_cnt_r;
    logic alarm_signal_defect, pointer_loss_defect;
    logic [15:0] ptr;
    logic act;
    logic fs_pend_r, mfs_pend_r, lo_pend_r;
    logic first_hit;
    logic [31:0] ones_wait_r;

    assign ptr = {hi_r, stream_in.data};
    ////////////////////////////////////////////////////////////////
    // frame marks: only the first slot bytes of a frame pair up as the pointer
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            fs_pend_r <= 1'b0;
            mfs_pend_r <= 1'b0;
            lo_pend_r <= 1'b0;
        end else if (tick) begin
            if (stream_in.fs) begin
                fs_pend_r <= 1'b1;
                mfs_pend_r <= stream_in.mfs;
                lo_pend_r <= 1'b1;
            end else if (slot_hit) begin
                fs_pend_r <= 1'b0;
                if (ptr_lo) begin
                    lo_pend_r <= 1'b0;
                end
            end
        end
    end
    assign first_hit = slot_hit & fs_pend_r;

    ////////////////////////////////////////////////////////////////
    // pointer interpreter
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            hi_r <= 8'h00;
        end else if (tick && first_hit && ptr_hi) begin
            hi_r <= stream_in.data;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pi_r <= PI_LOP;
            ndf_cnt_r <= '0;
            ais_cnt_r <= '0;
        end else if (tick && slot_hit && ptr_lo && lo_pend_r) begin
            if (ptr == PTR_ALL_ONES) begin
                ndf_cnt_r <= '0;
                ais_cnt_r <= ais_cnt_r + 4'd1;
                if (ais_cnt_r + 4'd1 >= 4'(PI_AIS_CNT)) begin
                    pi_r <= PI_AIS;
                end
            end else begin
                ais_cnt_r <= '0;
                if (ptr[15:12] == 4'b1001 || ptr[15:12] == 4'b0110) begin
                    ndf_cnt_r <= ndf_cnt_r + 4'd1;
                    if (ndf_cnt_r + 4'd1 >= 4'(PI_NDF_CNT)) begin
                        pi_r <= PI_LOP;
                    end
                end else begin
                    ndf_cnt_r <= '0;
                    pi_r <= PI_NORM;
                end
            end
        end
    end
    assign alarm_signal_defect = pi_r == PI_AIS;
    assign pointer_loss_defect = pi_r == PI_LOP;
    assign act = alarm_signal_defect | pointer_loss_defect | trail_fail_in;

    ////////////////////////////////////////////////////////////////
    // outputs
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            sink_data_out <= '{data: DATA_ONES, fs: 1'b0, mfs: 1'b0};
        end else if (tick) begin
            sink_data_out.fs <= first_hit;
            sink_data_out.mfs <= first_hit & mfs_pend_r;
            // one byte of latency is far inside either limit
            if (slot_hit) begin
                sink_data_out.data <= (act || !function_activate) ? DATA_ONES : stream_in.data;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            stat <= '0;
        end else begin
            stat.all_ones_insert_action <= act;
            stat.server_fail_out_action <= act;
            stat.alarm_signal_fault_cause <= function_activate & alarm_signal_defect & ~trail_fail_in
                & alarm_report_enable;
            stat.pointer_loss_fault_cause <= function_activate & pointer_loss_defect
                & ~trail_fail_in;
        end
    end

    a_ais_limit: assert property (@(posedge mclk) disable iff (!rst_b)
        act && tick && slot_hit |=> sink_data_out.data == DATA_ONES)
        else $error("all ones not inserted");
    a_lop_cause: assert property (@(posedge mclk) disable iff (!rst_b)
        stat.pointer_loss_fault_cause |-> $past(pointer_loss_defect) && !$past(trail_fail_in))
        else $error("lop cause without defect");
    a_ais_cause: assert property (@(posedge mclk) disable iff (!rst_b)
        stat.alarm_signal_fault_cause |-> $past(alarm_report_enable) && !$past(trail_fail_in))
        else $error("ais cause while masked");
    a_ssf_follow: assert property (@(posedge mclk) disable iff (!rst_b)
        trail_fail_in |=> stat.server_fail_out_action)
        else $error("ssf not raised");
    a_inactive_ones: assert property (@(posedge mclk) disable iff (!rst_b)
        !function_activate && tick && slot_hit |=> sink_data_out.data == DATA_ONES)
        else $error("inactive sink passes data");

    // limit far beyond a delay range, so a helper count; a stopped link clock would trip it
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ones_wait_r <= '0;
        end else if (act && sink_data_out.data != DATA_ONES) begin
            ones_wait_r <= ones_wait_r + 32'd1;
        end else begin
            ones_wait_r <= '0;
        end
    end
    a_ais_time: assert property (@(posedge mclk) disable iff (!rst_b)
        ones_wait_r < AIS_CYC)
        else $error("all ones inserted late");
endmodule : ptr_sink
`default_nettype wire

// ==== logic/mf_align.sv ====
// Purpose: multiframe alignment and label check on the label byte
// Assumes: label_stb pulses once per frame with the byte on label_byte
// Notes: loss timer counts mclk cycles while out of multiframe
`timescale 1ns/10ps
`default_nettype none
module mf_align
    import tug3_sink_pkg::*;
#(
    parameter int LOSS_CYC = LOM_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic label_stb,
    input wire logic [7:0] multiframe_label_byte,
    output logic label_mismatch_defect,
    output logic multiframe_loss_defect,
    output logic in_multiframe_state
);
    logic [1:0] exp_r;
    logic [2:0] good_r;
    logic [31:0] oom_cnt_r;
    logic ok;

    assign ok = multiframe_label_byte[MFB_HI:MFB_LO] == exp_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            exp_r <= MF_BIT_LO;
            good_r <= '0;
            in_multiframe_state <= 1'b0;
            label_mismatch_defect <= 1'b0;
        end else if (label_stb) begin
            label_mismatch_defect <= multiframe_label_byte[LABEL_HI:LABEL_LO] != EXP_LABEL;
            exp_r <= ok ? exp_r + 2'd1 : multiframe_label_byte[MFB_HI:MFB_LO] + 2'd1;
            if (!ok) begin
                good_r <= '0;
                in_multiframe_state <= 1'b0;
            end else if (good_r + 3'd1 >= 3'(MF_RECOVER)) begin
                in_multiframe_state <= 1'b1;
            end else begin
                good_r <= good_r + 3'd1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            oom_cnt_r <= '0;
            multiframe_loss_defect <= 1'b0;
        end else if (in_multiframe_state) begin
            oom_cnt_r <= '0;
            multiframe_loss_defect <= 1'b0;
        end else if (oom_cnt_r >= 32'(LOSS_CYC)) begin
            multiframe_loss_defect <= 1'b1;
        end else begin
            oom_cnt_r <= oom_cnt_r + 32'd1;
        end
    end

    a_lom_clear: assert property (@(posedge mclk) disable iff (!rst_b)
        in_multiframe_state |=> !multiframe_loss_defect)
        else $error("lom held in multiframe");
endmodule : mf_align
`default_nettype wire

// ==== logic/tug3_sink.sv ====
// Purpose: tug3 compound sink: label/multiframe correlation, trail term, tu3 and tu2 sinks
// Assumes: link clock and inputs from the higher order adaptation are asynchronous
// Notes: byte column counter locates timeslots; one tu3 and one tu2 sink instance
//
// Contract
// - label mismatch cause needs mismatch defect and no incoming trail fail.
// - multiframe loss cause needs loss defect, no trail fail, no mismatch.
// - tu3 sink recovers vc3 phase and outputs data with frame start.
// - tu3 sink takes only the timeslot chosen by its first index; with first index c (K_C) it takes no slot.
// - inactive sink outputs all ones, no fault causes; insertion and server fail still follow alarm, pointer loss or trail fail.
// - each sink detects alarm and pointer loss defects via pointer interpreter.
// - tu3 insertion and server fail follow alarm, pointer loss or trail fail.
// - tu3 all ones applied and removed within 250 us.
// - tu3 alarm cause needs defect, no trail fail, reporting enabled.
// - tu3 pointer loss cause needs defect and no trail fail.
// - alarm reporting optional, enable defaults false after reset; the enables are plain inputs with no reset value in the sink.
// - tu2 sink recovers vc2 phase and outputs data with frame start.
// - tu2 slot chosen by two indices, second 1-7 or 1-5.
// - tu2 insertion and server fail follow alarm, pointer loss or trail fail.
// - tu2 all ones applied and removed within 1 ms.
// - tu2 alarm cause needs defect, no trail fail, reporting enabled.
// - tu2 pointer loss cause needs defect and no trail fail.
// - label bits 3 to 5 compared against fixed code 100.
// - multiframe regained after four error-free consecutive frames.
// - multiframe loss declared after fixed out-of-multiframe time.
`timescale 1ns/10ps
`default_nettype none
module tug3_sink
    import tug3_sink_pkg::*;
#(
    parameter logic [1:0] TU3_K = K_A,
    parameter logic [1:0] TU2_K = K_A,
    parameter logic [2:0] TU2_L = 3'd1,
    parameter int LOSS_CYC = LOM_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic link_ck,
    input wire logic [7:0] link_d,
    input wire logic link_fs,
    input wire logic incoming_trail_signal_fail,
    input wire logic adapt_activate,
    input wire logic tu3_activate,
    input wire logic tu2_activate,
    input wire logic tu3_report_enable,
    input wire logic tu2_report_enable,
    output logic label_mismatch_fault_cause,
    output logic multiframe_loss_fault_cause,
    output logic tu3_trail_fail_action,
    output logic tug2_trail_fail_action,
    output stream_t tu3_out,
    output sink_stat_t tu3_stat,
    output stream_t tu2_out,
    output sink_stat_t tu2_stat
);
    ////////////////////////////////////////////////////////////////
    // synchronisers; link_ck edges become the byte tick
    logic ck_s1_r, ck_s2_r;
    logic [7:0] d_s1_r, d_s2_r;
    logic fs_s1_r, fs_s2_r, tsf_s1_r, tsf_s2_r;
    logic ck_d_r;
    logic tick;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ck_s1_r <= 1'b0;
            ck_s2_r <= 1'b0;
            d_s1_r <= '0;
            d_s2_r <= '0;
            fs_s1_r <= 1'b0;
            fs_s2_r <= 1'b0;
            tsf_s1_r <= 1'b1;
            tsf_s2_r <= 1'b1;
            ck_d_r <= 1'b0;
        end else begin
            ck_s1_r <= link_ck;
            ck_s2_r <= ck_s1_r;
            ck_d_r <= ck_s2_r;
            d_s1_r <= link_d;
            d_s2_r <= d_s1_r;
            fs_s1_r <= link_fs;
            fs_s2_r <= fs_s1_r;
            tsf_s1_r <= incoming_trail_signal_fail;
            tsf_s2_r <= tsf_s1_r;
        end
    end
    // data sampled on the rising link edge, which sits mid-bit after two stages
    assign tick = ck_s2_r & ~ck_d_r;

    ////////////////////////////////////////////////////////////////
    // column counter: byte 0 label, then interleaved slots per tug3 index
    logic [7:0] col_r;
    logic [1:0] k_now;
    logic [2:0] l_now;
    logic [1:0] frm_r;
    logic label_stb;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            col_r <= '0;
            frm_r <= '0;
        end else if (tick) begin
            if (fs_s2_r) begin
                col_r <= 8'd1;
                frm_r <= frm_r + 2'd1;
            end else begin
                col_r <= col_r + 8'd1;
            end
        end
    end
    assign label_stb = tick & fs_s2_r;
    assign k_now = 2'(col_r % 8'd3);
    assign l_now = 3'(((col_r / 8'd3) % 8'd7) + 8'd1);

    function automatic logic slot_ok(input logic [1:0] k, input logic [2:0] l);
        slot_ok = (k == K_C) ? (l <= L_MAX_C) : (l <= L_MAX_AB);
    endfunction : slot_ok

    logic tu3_hit, tu2_hit, ptr_hi, ptr_lo;
    // col_r still holds the last column on the label tick, so that tick is masked
    assign tu3_hit = !fs_s2_r && (col_r != 8'd0) && (k_now == TU3_K) && (TU3_K != K_C);
    assign tu2_hit = !fs_s2_r && (col_r != 8'd0) && (k_now == TU2_K) && (l_now == TU2_L)
        && slot_ok(TU2_K, TU2_L);
    assign ptr_hi = col_r < 8'd24;
    assign ptr_lo = col_r >= 8'd24 && col_r < 8'd48;

    ////////////////////////////////////////////////////////////////
    // label and multiframe
    logic label_mismatch_defect, multiframe_loss_defect, in_mf;
    logic [7:0] label_byte;
    assign label_byte = d_s2_r;

    mf_align #(.LOSS_CYC(LOSS_CYC)) u_mf (
        .mclk(mclk),
        .rst_b(rst_b),
        .label_stb(label_stb),
        .multiframe_label_byte(label_byte),
        .label_mismatch_defect(label_mismatch_defect),
        .multiframe_loss_defect(multiframe_loss_defect),
        .in_multiframe_state(in_mf)
    );

    logic tu3_server_fail_in, tug2_server_fail_in;
    assign tu3_server_fail_in = ~adapt_activate | label_mismatch_defect;
    assign tug2_server_fail_in = ~adapt_activate | label_mismatch_defect | multiframe_loss_defect;

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            label_mismatch_fault_cause <= 1'b0;
            multiframe_loss_fault_cause <= 1'b0;
            tu3_trail_fail_action <= 1'b1;
            tug2_trail_fail_action <= 1'b1;
        end else begin
            label_mismatch_fault_cause <= adapt_activate & label_mismatch_defect & ~tsf_s2_r;
            multiframe_loss_fault_cause <= adapt_activate & multiframe_loss_defect & ~tsf_s2_r
                & ~label_mismatch_defect;
            tu3_trail_fail_action <= tu3_server_fail_in;
            tug2_trail_fail_action <= tug2_server_fail_in;
        end
    end

    ////////////////////////////////////////////////////////////////
    // lower order sinks; enables are inputs so reset default false is the driver's job
    stream_t in_s;
    assign in_s = '{data: d_s2_r, fs: fs_s2_r, mfs: fs_s2_r & in_mf & (frm_r == 2'b00)};

    ptr_sink #(.AIS_US(TU3_AIS_US)) u_tu3 (
        .mclk(mclk),
        .rst_b(rst_b),
        .tick(tick),
        .slot_hit(tu3_hit),
        .ptr_hi(ptr_hi),
        .ptr_lo(ptr_lo),
        .stream_in(in_s),
        .trail_fail_in(tu3_trail_fail_action),
        .function_activate(tu3_activate),
        .alarm_report_enable(tu3_report_enable),
        .sink_data_out(tu3_out),
        .stat(tu3_stat)
    );

    ptr_sink #(.AIS_US(TU2_AIS_US)) u_tu2 (
        .mclk(mclk),
        .rst_b(rst_b),
        .tick(tick),
        .slot_hit(tu2_hit),
        .ptr_hi(ptr_hi),
        .ptr_lo(ptr_lo),
        .stream_in(in_s),
        .trail_fail_in(tug2_trail_fail_action),
        .function_activate(tu2_activate),
        .alarm_report_enable(tu2_report_enable),
        .sink_data_out(tu2_out),
        .stat(tu2_stat)
    );

    a_plm_cause: assert property (@(posedge mclk) disable iff (!rst_b)
        label_mismatch_fault_cause |-> $past(label_mismatch_defect) && !$past(tsf_s2_r))
        else $error("plm cause without defect");
    a_lom_cause: assert property (@(posedge mclk) disable iff (!rst_b)
        multiframe_loss_fault_cause |-> !$past(label_mismatch_defect))
        else $error("lom cause during mismatch");
    a_trail_copy: assert property (@(posedge mclk) disable iff (!rst_b)
        label_mismatch_defect |=> tu3_trail_fail_action && tug2_trail_fail_action)
        else $error("trail fail not copied");
endmodule : tug3_sink
`default_nettype wire

// ==== verification/hi_adapt_model.sv ====
// Purpose: far side model, higher order adaptation feeding the tug3 sink
// Assumes: 48 byte columns a frame, column 0 carries the label byte
// Notes: all slots share one pointer word; payload byte is {slot, column}
`timescale 1ns/10ps
`default_nettype none
module hi_adapt_model
    import tug3_sink_pkg::*;
#(
    parameter int COLS = 48
) (
    input wire logic run,
    input wire logic [2:0] label,
    input wire logic mf_bad,
    input wire logic [15:0] ptr,
    output logic link_ck,
    output logic [7:0] link_d,
    output logic link_fs,
    output int frame_cnt
);
    int col;
    logic [1:0] mf_r;
    ////////////////////////////////////////////////////////////
    function automatic logic [7:0] byte_at(input int c);
        if (c == 0) begin
            return {mf_r, label, 3'b000};
        end
        if (c <= 21) begin
            return ptr[15:8];
        end
        if (c >= 24 && c <= 44) begin
            return ptr[7:0];
        end
        return {2'(c % 3), 6'(c)};
    endfunction : byte_at
    ////////////////////////////////////////////////////////////
    initial begin
        link_ck = 1'b0;
        link_d = 8'h00;
        link_fs = 1'b0;
        frame_cnt = 0;
        col = 0;
        mf_r = 2'd0;
        #13;
        forever begin
            #40;
            link_ck = 1'b0;
            if (!run) begin
                link_d = ~link_d; // idle line toggles, a stale byte never looks valid
                link_fs = 1'b0;
            end else begin
                link_fs = (col == 0);
                link_d = byte_at(col);
                if (col == 0 && !mf_bad) begin
                    mf_r = mf_r + 2'd1; // stuck count breaks the sequence
                end
                col = (col + 1) % COLS;
                if (col == 0) begin
                    frame_cnt = frame_cnt + 1;
                end
            end
            #40;
            link_ck = run; // stands still while stopped
        end
    end
endmodule : hi_adapt_model
`default_nettype wire

// ==== verification/tug3_sink_tb.sv ====
// Purpose: self-checking bench for the tug3 compound sink
// Assumes: tu3 on slot b, tu2 on slot a index 2, short loss timer
// Notes: checks are taken 24 mclk after frame ends, past the sync delay
`timescale 1ns/10ps
`default_nettype none
module tug3_sink_tb;
    import tug3_sink_pkg::*;
    localparam int CYC_MAX = 75000;
    localparam logic [15:0] PTR_OK = 16'h0330;
    logic mclk, rst_b, run, mf_bad, trail_fail, adapt_act, tu3_act, tu2_act, tu3_rep, tu2_rep, mon_on, mf_q;
    logic [2:0] label;
    logic [15:0] ptr;
    logic link_ck, link_fs, lab_c, mf_c, tu3_tf, tu2_tf;
    logic [7:0] link_d;
    stream_t tu3_out, tu2_out;
    sink_stat_t tu3_stat, tu2_stat;
    int frame_cnt;
    int err_count = 0;
    int compares = 0;
    int cyc = 0;
    int slot_err = 0;
    int fs3 = 0;
    int fs2 = 0;
    int mf_rise = 0;
    int mf_base = 0;
    int mfs3 = 0;
    int mfs2 = 0;
    ////////////////////////////////////////////////////////////
    hi_adapt_model i_hi_adapt_model (.run(run), .label(label), .mf_bad(mf_bad), .ptr(ptr), .link_ck(link_ck),
        .link_d(link_d), .link_fs(link_fs), .frame_cnt(frame_cnt));
    tug3_sink #(.TU3_K(K_B), .TU2_K(K_A), .TU2_L(3'd2), .LOSS_CYC(200)) i_tug3_sink (.mclk(mclk), .rst_b(rst_b),
        .link_ck(link_ck), .link_d(link_d), .link_fs(link_fs), .incoming_trail_signal_fail(trail_fail),
        .adapt_activate(adapt_act), .tu3_activate(tu3_act), .tu2_activate(tu2_act),
        .tu3_report_enable(tu3_rep), .tu2_report_enable(tu2_rep), .label_mismatch_fault_cause(lab_c),
        .multiframe_loss_fault_cause(mf_c), .tu3_trail_fail_action(tu3_tf), .tug2_trail_fail_action(tu2_tf),
        .tu3_out(tu3_out), .tu3_stat(tu3_stat), .tu2_out(tu2_out), .tu2_stat(tu2_stat));
    ////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    function automatic logic stray(input logic [7:0] d);
        return d !== DATA_ONES && d !== PTR_OK[15:8] && d !== PTR_OK[7:0];
    endfunction : stray

    task automatic end_of_test();
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic stat_chk(input string what, input logic [3:0] e3, input logic [3:0] e2);
        check(what, 16'({tu3_stat, tu2_stat}), 16'({e3, e2}));
    endtask : stat_chk

    // whole frames plus margin for the link sync and the answer register
    task automatic frames(input int n);
        int target;
        target = frame_cnt + n;
        while (frame_cnt < target) begin
            @(posedge mclk);
        end
        repeat (24) @(posedge mclk);
        @(negedge mclk);
    endtask : frames

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        mf_q <= mf_c;
        mf_rise <= mf_rise + int'(mf_c === 1'b1 && mf_q === 1'b0);
        if (mon_on) begin
            slot_err <= slot_err + int'(stray(tu3_out.data) && tu3_out.data[7:6] !== 2'b01)
                + int'(stray(tu2_out.data) && tu2_out.data !== 8'h2d);
            fs3 <= fs3 + int'(tu3_out.fs === 1'b1);
            fs2 <= fs2 + int'(tu2_out.fs === 1'b1);
            mfs3 <= mfs3 + int'(tu3_out.mfs === 1'b1);
            mfs2 <= mfs2 + int'(tu2_out.mfs === 1'b1);
        end
        if (cyc == CYC_MAX) begin
            err_count++;
            $display("timeout after %0d cycles", cyc);
            end_of_test();
        end
    end
    ////////////////////////////////////////////////////////////
    initial begin
        rst_b = 1'b0;
        run = 1'b1;
        label = 3'b100;
        mf_bad = 1'b0;
        ptr = PTR_OK;
        trail_fail = 1'b0;
        adapt_act = 1'b1;
        tu3_act = 1'b0;
        tu2_act = 1'b0;
        tu3_rep = 1'b0; // reporting off by default
        tu2_rep = 1'b0;
        mon_on = 1'b0;
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        check("reset causes", 16'({lab_c, mf_c, tu3_stat, tu2_stat}), 16'h0000);
        check("reset trail fail", 16'({tu3_tf, tu2_tf}), 16'h0003);
        @(posedge mclk);
        rst_b <= 1'b1;
        frames(3);
        check("inactive data", {tu3_out.data, tu2_out.data}, 16'hffff);
        check("inactive causes", 16'({tu3_stat[1:0], tu2_stat[1:0]}), 16'h0000);
        $display("test inactive done");
        @(posedge mclk);
        tu3_act <= 1'b1; // only sinks matching the structure
        tu2_act <= 1'b1;
        mon_on <= 1'b1;
        frames(6);
        mon_on = 1'b0;
        check("normal flags", 16'({lab_c, mf_c, tu3_tf, tu2_tf}), 16'h0000);
        stat_chk("normal stat", 4'h0, 4'h0);
        check("normal data", 16'({tu3_out.data === DATA_ONES, tu2_out.data === DATA_ONES}), 16'h0000);
        check("slot selection", 16'(slot_err), 16'h0000);
        check("frame start", 16'({fs3 > 0, fs2 > 0}), 16'h0003);
        check("multiframe start", 16'({mfs3 > 0, mfs2 > 0}), 16'h0003);
        $display("test normal done");
        @(posedge mclk);
        ptr <= PTR_ALL_ONES;
        frames(4);
        stat_chk("ais unreported", 4'hc, 4'hc);
        check("ais data", {tu3_out.data, tu2_out.data}, 16'hffff);
        @(posedge mclk);
        tu3_rep <= 1'b1;
        tu2_rep <= 1'b1;
        frames(1);
        stat_chk("alarm_report_enable", 4'he, 4'he);
        @(posedge mclk);
        ptr <= PTR_OK;
        frames(5);
        stat_chk("ais cleared", 4'h0, 4'h0);
        check("data resumed", 16'({tu3_out.data === DATA_ONES, tu2_out.data === DATA_ONES}), 16'h0000);
        $display("test alarm done");
        @(posedge mclk);
        ptr <= 16'h9000;
        frames(10);
        stat_chk("pointer loss", 4'hd, 4'hd);
        @(posedge mclk);
        label <= 3'b101;
        frames(6);
        check("mismatch", 16'({lab_c, mf_c, tu3_tf, tu2_tf}), 16'h000b);
        stat_chk("loss under trail fail", 4'hc, 4'hc);
        @(posedge mclk);
        trail_fail <= 1'b1;
        frames(1);
        check("mismatch masked", 16'({lab_c, mf_c}), 16'h0000);
        @(posedge mclk);
        trail_fail <= 1'b0;
        label <= 3'b100;
        ptr <= PTR_OK;
        frames(8);
        check("label regained", 16'({lab_c, mf_c, tu3_tf, tu2_tf}), 16'h0000);
        stat_chk("pointer regained", 4'h0, 4'h0);
        $display("test pointer and label done");
        mf_base = mf_rise;
        @(posedge mclk);
        mf_bad <= 1'b1;
        frames(3);
        check("multiframe loss", 16'({lab_c, mf_c, tu3_tf, tu2_tf}), 16'h0005);
        stat_chk("tug2 fail only", 4'h0, 4'hc);
        check("loss raised once", 16'(mf_rise - mf_base), 16'h0001);
        @(posedge mclk);
        trail_fail <= 1'b1;
        frames(1);
        check("loss masked", 16'(mf_c), 16'h0000);
        @(posedge mclk);
        trail_fail <= 1'b0;
        label <= 3'b101;
        frames(6);
        check("loss under mismatch", 16'({lab_c, mf_c}), 16'h0002);
        @(posedge mclk);
        label <= 3'b100;
        mf_bad <= 1'b0;
        frames(8);
        check("multiframe regained", 16'({lab_c, mf_c, tu3_tf, tu2_tf}), 16'h0000);
        $display("test multiframe done");
        @(posedge mclk);
        adapt_act <= 1'b0;
        mf_bad <= 1'b1;
        frames(2);
        check("adapt off", 16'({lab_c, mf_c, tu3_tf, tu2_tf}), 16'h0003);
        $display("test adapt off done");
        end_of_test();
    end
endmodule : tug3_sink_tb
`default_nettype wire
